// File: rtl/cdio_ports.v
`timescale 1ns/1ps
`include "cdio_regs.vh"

module cdio_ports #(
  parameter NPORT = 12,
  parameter DEPTH = 256,
  parameter AW    = 8,
  parameter OPEN_COLLECTOR = 0
) (
  // Clock and reset
  input  wire                 clock_i,
  input  wire                 rst_i,
  // Register port
  input  wire [7:0]           reg_addr_i,
  input  wire [31:0]          reg_wdata_i,
  input  wire                 reg_wr_i,
  input  wire                 reg_rd_i,
  output reg  [31:0]          reg_rdata_o,
  // Link
  input  wire                 ext_strobe_in_i,
  output wire                 busy_o,
  // Port pins
  input  wire [NPORT*8-1:0]   port_in_i,
  output wire [NPORT*8-1:0]   port_out_o,
  output wire [NPORT*8-1:0]   port_oe_o
);

  localparam CW = AW + 1;

  // ---------------------------------------------------------------------------
  // Configuration state
  // ---------------------------------------------------------------------------
  reg  [NPORT-1:0]   drv_en_q;
  reg  [3:0]         mode_q;
  reg  [NPORT-1:0]   dir_q;
  reg                armed_q;
  reg                clk_inv_q;
  reg                bsy_inv_q;
  reg  [3:0]         sel_q;
  reg  [CW-1:0]      pulses_q;
  reg  [7:0]         async_q   [0:NPORT-1];
  reg  [CW-1:0]      index_q   [0:NPORT-1];
  reg  [CW-1:0]      loaded_q  [0:NPORT-1];
  reg  [CW-1:0]      points_q  [0:NPORT-1];
  reg  [7:0]         sync_out_q[0:NPORT-1];
  reg  [7:0]         mem_q     [0:NPORT*DEPTH-1];
  reg  [NPORT*8-1:0] pin_s1_q;
  reg  [NPORT*8-1:0] pin_s2_q;
  reg  [2:0]         stb_q;

  integer i;

  // ---------------------------------------------------------------------------
  // Strobe and pin synchronisers
  // ---------------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      stb_q    <= 3'h0;
      pin_s1_q <= {NPORT*8{1'b0}};
      pin_s2_q <= {NPORT*8{1'b0}};
    end else begin
      stb_q    <= {stb_q[1:0], ext_strobe_in_i};
      pin_s1_q <= port_in_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Active edge: rising when normal, falling when inverted.
  wire stb_lvl  = stb_q[1] ^ clk_inv_q;
  wire stb_prev = stb_q[2] ^ clk_inv_q;
  wire stb_edge = stb_lvl & ~stb_prev;
  wire step     = stb_edge & armed_q;

  // ---------------------------------------------------------------------------
  // Completion target
  // ---------------------------------------------------------------------------
  reg [CW-1:0] target;
  always @* begin
    target = {CW{1'b0}};
    for (i = 0; i < NPORT; i = i + 1) begin
      if (i < mode_q) begin
        if (dir_q[i] && loaded_q[i] > target)
          target = loaded_q[i];
        if (!dir_q[i] && points_q[i] > target)
          target = points_q[i];
      end
    end
  end

  wire [CW-1:0] pulses_nx = pulses_q + {{CW-1{1'b0}}, 1'b1};
  wire          done      = step && (pulses_nx >= target);

  wire [7:0] woff = reg_addr_i - `CDIO_A_ASYNC_BASE;
  wire       sel_ok = (sel_q < NPORT);
  wire [AW+3:0] sel_base = {sel_q, {AW{1'b0}}};

  // ---------------------------------------------------------------------------
  // Register writes and synchronous transfer
  // ---------------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      drv_en_q  <= `CDIO_RST_DRV_EN;
      mode_q    <= `CDIO_RST_MODE;
      dir_q     <= {NPORT{1'b0}};
      armed_q   <= 1'b0;
      clk_inv_q <= 1'b0;
      bsy_inv_q <= 1'b0;
      sel_q     <= 4'h0;
      pulses_q  <= `CDIO_RST_CNT;
      for (i = 0; i < NPORT; i = i + 1) begin
        async_q[i]    <= `CDIO_RST_BYTE;
        index_q[i]    <= `CDIO_RST_CNT;
        loaded_q[i]   <= `CDIO_RST_CNT;
        points_q[i]   <= `CDIO_RST_CNT;
        sync_out_q[i] <= `CDIO_RST_BYTE;
      end
    end else begin
      if (step) begin
        pulses_q <= pulses_nx;
        for (i = 0; i < NPORT; i = i + 1) begin
          if (i < mode_q) begin
            if (dir_q[i] && pulses_q < loaded_q[i])
              sync_out_q[i] <= mem_q[i*DEPTH + pulses_q[AW-1:0]];
            if (!dir_q[i] && pulses_q < points_q[i]) begin
              mem_q[i*DEPTH + pulses_q[AW-1:0]] <= pin_s2_q[i*8 +: 8];
              index_q[i] <= pulses_nx;
            end
          end
        end
        if (done)
          armed_q <= 1'b0;
      end
      if (reg_wr_i) begin
        case (reg_addr_i)
          `CDIO_A_DRV_EN: drv_en_q <= reg_wdata_i[NPORT-1:0];
          `CDIO_A_CTRL: begin
            armed_q   <= reg_wdata_i[`CDIO_CTRL_ARM];
            clk_inv_q <= reg_wdata_i[`CDIO_CTRL_CLK_INV];
            bsy_inv_q <= reg_wdata_i[`CDIO_CTRL_BSY_INV];
            if (reg_wdata_i[`CDIO_CTRL_ARM] && !armed_q) begin
              pulses_q <= `CDIO_RST_CNT;
              for (i = 0; i < NPORT; i = i + 1)
                if (!dir_q[i])
                  index_q[i] <= `CDIO_RST_CNT;
            end
          end
          `CDIO_A_MODE:
            if (reg_wdata_i[3:0] <= NPORT)
              mode_q <= reg_wdata_i[3:0];
          `CDIO_A_DIR: dir_q <= reg_wdata_i[NPORT-1:0];
          `CDIO_A_SEL: sel_q <= reg_wdata_i[3:0];
          // A capture port may rewind only within what it has stored.
          `CDIO_A_INDEX:
            if (sel_ok && reg_wdata_i[CW-1:0] <=
                (dir_q[sel_q] ? loaded_q[sel_q] : index_q[sel_q]))
              index_q[sel_q] <= reg_wdata_i[CW-1:0];
          `CDIO_A_DATA:
            if (sel_ok && index_q[sel_q] < DEPTH) begin
              mem_q[sel_base + index_q[sel_q][AW-1:0]] <= reg_wdata_i[7:0];
              index_q[sel_q] <= index_q[sel_q] + {{CW-1{1'b0}}, 1'b1};
              if (index_q[sel_q] >= loaded_q[sel_q])
                loaded_q[sel_q] <= index_q[sel_q] + {{CW-1{1'b0}}, 1'b1};
            end
          `CDIO_A_POINTS:
            if (sel_ok && reg_wdata_i[CW-1:0] <= DEPTH)
              points_q[sel_q] <= reg_wdata_i[CW-1:0];
          `CDIO_A_CLEAR:
            if (sel_ok) begin
              index_q[sel_q]  <= `CDIO_RST_CNT;
              loaded_q[sel_q] <= `CDIO_RST_CNT;
            end
          default: begin
            if (reg_addr_i >= `CDIO_A_ASYNC_BASE &&
                reg_addr_i <= `CDIO_A_ASYNC_TOP)
              async_q[woff[3:0]] <= reg_wdata_i[7:0];
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register reads, one cycle later
  // ---------------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
      case (reg_addr_i)
        `CDIO_A_DRV_EN: reg_rdata_o[NPORT-1:0] <= drv_en_q;
        `CDIO_A_CTRL: begin
          reg_rdata_o[`CDIO_CTRL_ARM]     <= armed_q;
          reg_rdata_o[`CDIO_CTRL_CLK_INV] <= clk_inv_q;
          reg_rdata_o[`CDIO_CTRL_BSY_INV] <= bsy_inv_q;
        end
        `CDIO_A_MODE:   reg_rdata_o[3:0] <= mode_q;
        `CDIO_A_DIR:    reg_rdata_o[NPORT-1:0] <= dir_q;
        `CDIO_A_STATUS: reg_rdata_o[`CDIO_ST_ARMED] <= armed_q;
        `CDIO_A_PULSES: reg_rdata_o[CW-1:0] <= pulses_q;
        `CDIO_A_SEL:    reg_rdata_o[3:0] <= sel_q;
        `CDIO_A_INDEX:
          if (sel_ok) reg_rdata_o[CW-1:0] <= index_q[sel_q];
        `CDIO_A_DATA:
          if (sel_ok)
            reg_rdata_o[7:0] <= mem_q[sel_base + index_q[sel_q][AW-1:0]];
        `CDIO_A_POINTS:
          if (sel_ok) reg_rdata_o[CW-1:0] <= points_q[sel_q];
        `CDIO_A_LOADED:
          if (sel_ok) reg_rdata_o[CW-1:0] <= loaded_q[sel_q];
        default: begin
          if (reg_addr_i >= `CDIO_A_ASYNC_BASE &&
              reg_addr_i <= `CDIO_A_ASYNC_TOP) begin
            // With OPEN_COLLECTOR == 0, an enabled asynchronous port reads back its written value; otherwise the pins are read.
            if (drv_en_q[woff[3:0]] && OPEN_COLLECTOR == 0)
              reg_rdata_o[7:0] <= async_q[woff[3:0]];
            else
              reg_rdata_o[7:0] <= pin_s2_q[woff[3:0]*8 +: 8];
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_pin
      wire is_sync = (g < mode_q);
      assign port_out_o[g*8 +: 8] = is_sync ? sync_out_q[g] : async_q[g];
      // Open collector: always driven, enable setting has no effect.
      assign port_oe_o[g*8 +: 8] =
        {8{(OPEN_COLLECTOR != 0) | drv_en_q[g]}};
    end
  endgenerate

  assign busy_o = armed_q ^ bsy_inv_q;

endmodule // cdio_ports

// File: rtl/cdio_regs.vh
`ifndef CDIO_REGS_VH
`define CDIO_REGS_VH

// ---------------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ---------------------------------------------------------------------------
`define CDIO_A_DRV_EN     8'h00
`define CDIO_A_CTRL       8'h01
`define CDIO_A_MODE       8'h02
`define CDIO_A_DIR        8'h03
`define CDIO_A_STATUS     8'h04
`define CDIO_A_PULSES     8'h05
`define CDIO_A_SEL        8'h06
`define CDIO_A_INDEX      8'h07
`define CDIO_A_DATA       8'h08
`define CDIO_A_POINTS     8'h09
`define CDIO_A_LOADED     8'h0A
`define CDIO_A_CLEAR      8'h0B
`define CDIO_A_ASYNC_BASE 8'h10
`define CDIO_A_ASYNC_TOP  8'h1B

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define CDIO_CTRL_ARM     0
`define CDIO_CTRL_CLK_INV 1
`define CDIO_CTRL_BSY_INV 2
`define CDIO_ST_ARMED     0

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define CDIO_RST_DRV_EN   12'h000
`define CDIO_RST_MODE     4'h0
`define CDIO_RST_BYTE     8'h00
`define CDIO_RST_CNT      9'h000

`endif

// File: sim/cdio_equip.sv
`timescale 1ns/1ps
module cdio_equip (
  // Link and pins
  output logic        strobe_o,
  output logic [95:0] pins_o
);
  initial begin
    strobe_o = 1'h0;
    pins_o = {12{8'h5A}};
  end

  // Strobe rests at its idle level between frames; 80 ns per pulse.
  task automatic burst(input int n, input logic inv);
    strobe_o = inv;
    #40;
    for (int k = 0; k < n; k++) begin
      pins_o = {12{8'hC0 + k[7:0]}};
      #40 strobe_o = ~inv;
      #40 strobe_o = inv;
    end
    pins_o = ~pins_o;
  endtask
endmodule // cdio_equip

// File: sim/cdio_ports_props.sv
`timescale 1ns/1ps
module cdio_ports_props #(
  parameter NPORT = 12
) (
  // Clock, reset and register port
  input wire               clock_i,
  input wire               rst_i,
  input wire [7:0]         reg_addr_i,
  input wire [31:0]        reg_wdata_i,
  input wire               reg_wr_i,
  input wire               reg_rd_i,
  input wire [31:0]        reg_rdata_o,
  // Link and pins
  input wire               ext_strobe_in_i,
  input wire               busy_o,
  input wire [NPORT*8-1:0] port_in_i,
  input wire [NPORT*8-1:0] port_out_o,
  input wire [NPORT*8-1:0] port_oe_o
);
  logic [3:0]         mode_q;
  logic               inv_q;
  logic [3:0]         pidx_q;
  logic [7:0]         sh_q;
  logic [NPORT*8-1:0] oe_exp;
  wire  [3:0]         pidx = reg_addr_i[3:0];
  wire                armed = busy_o ^ inv_q;
  wire                on_async = reg_addr_i[7:4] == 4'h1 && pidx < 4'hC
                                 && pidx >= mode_q;
  // A strobe change seen within the last seven cycles.
  wire                edge_recent = |(sh_q[7:1] ^ sh_q[6:0]);

  always_comb for (int p = 0; p < NPORT; p++) oe_exp[p*8 +: 8] = {8{reg_wdata_i[p]}};

  always_ff @(posedge clock_i) begin
    sh_q <= {sh_q[6:0], ext_strobe_in_i};
    pidx_q <= pidx;
    if (rst_i) begin
      mode_q <= 4'h0;
      inv_q <= 1'h0;
    end else if (reg_wr_i && reg_addr_i == 8'h02 && reg_wdata_i <= 32'h0C) begin
      mode_q <= reg_wdata_i[3:0];
    end else if (reg_wr_i && reg_addr_i == 8'h01) begin
      inv_q <= reg_wdata_i[2];
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  unmapped_read_a:
    assert property (reg_rd_i && reg_addr_i inside {[8'h0C:8'h0F], [8'h1C:8'hFF]}
      |=> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
  rdata_hold_a:
    assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
  oe_write_a:
    assert property (reg_wr_i && reg_addr_i == 8'h00 |=> port_oe_o == $past(oe_exp))
      else $error("driver enables not per port");
  oe_keep_a:
    assert property (!(reg_wr_i && reg_addr_i == 8'h00) |=> $stable(port_oe_o))
      else $error("driver enables changed on their own");
  async_write_a:
    assert property (reg_wr_i && on_async
      |=> port_out_o[pidx_q*8 +: 8] == $past(reg_wdata_i[7:0]))
      else $error("async byte not driven next cycle");
  async_back_a:
    assert property (reg_rd_i && on_async && port_oe_o[pidx*8]
      |=> reg_rdata_o == {24'h0, $past(port_out_o[pidx*8 +: 8])})
      else $error("readback differs from driven byte");
  busy_pol_a:
    assert property (reg_rd_i && reg_addr_i == 8'h04
      |=> reg_rdata_o[0] == ($past(busy_o) ^ $past(inv_q)))
      else $error("busy polarity wrong");
  idle_static_a:
    assert property (!armed && !$past(armed) && !reg_wr_i |=> $stable(port_out_o))
      else $error("outputs moved while disarmed");
  step_cause_a:
    assert property ($changed(port_out_o) && !$past(reg_wr_i) |-> edge_recent)
      else $error("output stepped without a strobe edge");
endmodule // cdio_ports_props

bind cdio_ports cdio_ports_props #(.NPORT(NPORT)) props_u (.*);

// File: sim/test_clocked_digital_io_ports.sv
`timescale 1ns/1ps
module test_clocked_digital_io_ports;
  logic        clock_i = 1'h0;
  logic        rst_i = 1'h1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'h0;
  logic        reg_rd_i = 1'h0;
  wire  [31:0] reg_rdata_o;
  wire         ext_strobe_in_i;
  wire         busy_o;
  wire  [95:0] port_in_i;
  wire  [95:0] port_out_o;
  wire  [95:0] port_oe_o;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;

  always #2.5 clock_i = ~clock_i;

  cdio_ports dut_u (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .ext_strobe_in_i(ext_strobe_in_i),
    .busy_o(busy_o), .port_in_i(port_in_i), .port_out_o(port_out_o),
    .port_oe_o(port_oe_o));
  cdio_equip equip_u (.strobe_o(ext_strobe_in_i), .pins_o(port_in_i));

  // --------------------------------------------------------------------------
  // Bus and compare helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'h0;
    #1 chk(reg_rdata_o, e);
  endtask

  task automatic t_async;
    wr(8'h00, 32'hFF7);
    for (int p = 11; p >= 0; p--) wr(8'h10 + p[7:0], 32'hA0 + p);
    for (int p = 11; p >= 0; p--) rd(8'h10 + p[7:0], p == 3 ? 32'h5A : 32'hA0 + p);
    chk(port_oe_o[31:24], 8'h00);
    chk(port_out_o[95:88], 8'hAB);
    rd(8'h0C, 32'h0);
    $display("async test done");
  endtask

  task automatic t_sync;
    wr(8'h00, 32'h1);
    wr(8'h02, 32'h2);
    wr(8'h03, 32'h1);
    wr(8'h06, 32'h0);
    wr(8'h08, 32'h11);
    wr(8'h08, 32'h22);
    wr(8'h08, 32'h33);
    rd(8'h0A, 32'h3);
    wr(8'h06, 32'h1);
    wr(8'h09, 32'h2);
    wr(8'h01, 32'h1);
    equip_u.burst(2, 1'h0);
    rd(8'h04, 32'h1);
    chk(port_out_o[7:0], 8'h22);
    equip_u.burst(1, 1'h0);
    rd(8'h04, 32'h0);
    rd(8'h05, 32'h3);
    rd(8'h07, 32'h2);
    wr(8'h07, 32'h0);
    rd(8'h08, 32'hC0);
    $display("sync test done");
  endtask

  task automatic t_inv;
    wr(8'h01, 32'h6);
    #1 chk(busy_o, 1'h1);
    equip_u.burst(2, 1'h1);
    rd(8'h05, 32'h3);
    wr(8'h01, 32'h7);
    #1 chk(busy_o, 1'h0);
    equip_u.burst(3, 1'h1);
    rd(8'h05, 32'h3);
    chk(busy_o, 1'h1);
    $display("polarity test done");
  endtask

  task automatic final_report;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'h0;
    t_async();
    t_sync();
    t_inv();
    final_report();
  end
endmodule // test_clocked_digital_io_ports
